// *** rtl/chb_coeff_pkg.sv ***
package chb_coeff_pkg;

    // Register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Byte offsets of the three registers
    localparam logic [11:0] CENTER_TAP_OFFSET  = 12'h450;
    localparam logic [11:0] SIXTH_TAP_OFFSET   = 12'h453;
    localparam logic [11:0] SEVENTH_TAP_OFFSET = 12'h455;

    // Register sizes in bytes
    localparam int CENTER_TAP_BYTES  = 3;
    localparam int SIXTH_TAP_BYTES   = 2;
    localparam int SEVENTH_TAP_BYTES = 2;

    // Coefficient field widths, field always starts at bit 0
    localparam int CENTER_TAP_FIELD_W = 18;
    localparam int OUTER_TAP_FIELD_W  = 12;

    // Reset values
    localparam logic [23:0] CENTER_TAP_RESET = 24'h000000;
    localparam logic [15:0] SIXTH_TAP_RESET  = 16'h0000;
    localparam logic [15:0] SEVENTH_TAP_RESET = 16'h0000;

    // Answer to an unmapped read
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// *** rtl/coeff_reg_cell.sv ***
`timescale 1ns/10ps

module coeff_reg_cell #(
    parameter int                     NBYTES    = 2,
    parameter int                     FIELD_W   = 12,
    parameter logic [NBYTES*8-1:0]    RESET_VAL = '0
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 wr_en,
    input  wire logic [1:0]           byte_idx,
    input  wire logic [7:0]           wdata,
    output logic      [NBYTES*8-1:0]  value,
    output logic      [7:0]           rd_byte
);

    localparam logic [NBYTES*8-1:0] ONE       = {{(NBYTES*8-1){1'b0}}, 1'b1};
    localparam logic [NBYTES*8-1:0] READ_MASK = ~(ONE << (FIELD_W - 1));

    logic [NBYTES*8-1:0] value_reg;
    wire  [NBYTES*8-1:0] readback;
    wire                 idx_in_range;

    // Top bit of the field is lost on readback; the filter still sees it
    assign readback     = value_reg & READ_MASK;
    assign idx_in_range = (32'(byte_idx) < NBYTES);
    assign rd_byte      = idx_in_range ? readback[8*byte_idx +: 8] : 8'h00;
    assign value        = value_reg;

    // One process owns the whole register, so each bit has a single driver
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RESET_VAL;
        end else if (wr_en && idx_in_range) begin
            value_reg[8*byte_idx +: 8] <= wdata;
        end
    end

endmodule

// *** rtl/chb_fir_coeff_regs.sv ***
`timescale 1ns/10ps

module chb_fir_coeff_regs (
    input  wire logic                                   mclk,
    input  wire logic                                   rst_n,
    input  wire logic [chb_coeff_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic [chb_coeff_pkg::DATA_W-1:0]       reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic      [chb_coeff_pkg::DATA_W-1:0]       reg_rdata,
    input  wire logic                                   dual_channel_mode,
    output logic      [chb_coeff_pkg::CENTER_TAP_FIELD_W-1:0] center_tap_coeff,
    output logic      [chb_coeff_pkg::OUTER_TAP_FIELD_W-1:0]  sixth_tap_coeff,
    output logic      [chb_coeff_pkg::OUTER_TAP_FIELD_W-1:0]  seventh_tap_coeff,
    output logic                                        chb_coeff_active,
    output logic                                        coeff_update
);

    localparam int CW = chb_coeff_pkg::CENTER_TAP_FIELD_W;
    localparam int OW = chb_coeff_pkg::OUTER_TAP_FIELD_W;

    // Address decode: each register spans consecutive byte offsets
    wire [11:0] center_diff;
    wire [11:0] sixth_diff;
    wire [11:0] seventh_diff;
    wire        center_hit;
    wire        sixth_hit;
    wire        seventh_hit;

    assign center_diff  = reg_addr - chb_coeff_pkg::CENTER_TAP_OFFSET;
    assign sixth_diff   = reg_addr - chb_coeff_pkg::SIXTH_TAP_OFFSET;
    assign seventh_diff = reg_addr - chb_coeff_pkg::SEVENTH_TAP_OFFSET;
    assign center_hit   = (center_diff < 12'(chb_coeff_pkg::CENTER_TAP_BYTES));
    assign sixth_hit    = (sixth_diff < 12'(chb_coeff_pkg::SIXTH_TAP_BYTES));
    assign seventh_hit  = (seventh_diff < 12'(chb_coeff_pkg::SEVENTH_TAP_BYTES));

    wire center_wr  = reg_wr && center_hit;
    wire sixth_wr   = reg_wr && sixth_hit;
    wire seventh_wr = reg_wr && seventh_hit;

    // Storage; reserved bits are plain read/write and keep what is written
    wire [23:0] center_value;
    wire [15:0] sixth_value;
    wire [15:0] seventh_value;
    wire [7:0]  center_rd;
    wire [7:0]  sixth_rd;
    wire [7:0]  seventh_rd;

    coeff_reg_cell #(
        .NBYTES    (chb_coeff_pkg::CENTER_TAP_BYTES),
        .FIELD_W   (CW),
        .RESET_VAL (chb_coeff_pkg::CENTER_TAP_RESET)
    ) u_center (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (center_wr),
        .byte_idx (center_diff[1:0]),
        .wdata    (reg_wdata),
        .value    (center_value),
        .rd_byte  (center_rd)
    );

    coeff_reg_cell #(
        .NBYTES    (chb_coeff_pkg::SIXTH_TAP_BYTES),
        .FIELD_W   (OW),
        .RESET_VAL (chb_coeff_pkg::SIXTH_TAP_RESET)
    ) u_sixth (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (sixth_wr),
        .byte_idx (sixth_diff[1:0]),
        .wdata    (reg_wdata),
        .value    (sixth_value),
        .rd_byte  (sixth_rd)
    );

    coeff_reg_cell #(
        .NBYTES    (chb_coeff_pkg::SEVENTH_TAP_BYTES),
        .FIELD_W   (OW),
        .RESET_VAL (chb_coeff_pkg::SEVENTH_TAP_RESET)
    ) u_seventh (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (seventh_wr),
        .byte_idx (seventh_diff[1:0]),
        .wdata    (reg_wdata),
        .value    (seventh_value),
        .rd_byte  (seventh_rd)
    );

    // Read select; masked bytes come from the cells
    wire [7:0] rd_sel;
    assign rd_sel = center_hit  ? center_rd  :
                    sixth_hit   ? sixth_rd   :
                    seventh_hit ? seventh_rd :
                    chb_coeff_pkg::UNMAPPED_READ;

    logic [7:0] reg_rdata_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= 8'h00;
        end else begin
            // Data valid only in the cycle after the strobe
            reg_rdata_reg <= reg_rd ? rd_sel : 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_reg;

    // Filter side: full written field in dual-channel mode, zero otherwise; not the masked readback
    wire [CW-1:0] center_next = dual_channel_mode ? center_value[CW-1:0] : '0;
    wire [OW-1:0] sixth_next  = dual_channel_mode ? sixth_value[OW-1:0] : '0;
    wire [OW-1:0] seventh_next = dual_channel_mode ? seventh_value[OW-1:0] : '0;
    wire          update_next = center_wr || sixth_wr || seventh_wr;

    logic [CW-1:0] center_coeff_reg;
    logic [OW-1:0] sixth_coeff_reg;
    logic [OW-1:0] seventh_coeff_reg;
    logic          active_reg;
    logic          update_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            center_coeff_reg  <= '0;
            sixth_coeff_reg   <= '0;
            seventh_coeff_reg <= '0;
            active_reg        <= 1'b0;
            update_reg        <= 1'b0;
        end else begin
            center_coeff_reg  <= center_next;
            sixth_coeff_reg   <= sixth_next;
            seventh_coeff_reg <= seventh_next;
            active_reg        <= dual_channel_mode;
            update_reg        <= update_next;
        end
    end

    assign center_tap_coeff  = center_coeff_reg;
    assign sixth_tap_coeff   = sixth_coeff_reg;
    assign seventh_tap_coeff = seventh_coeff_reg;
    assign chb_coeff_active  = active_reg;
    assign coeff_update      = update_reg;

endmodule

// *** test/chb_fir_coeff_regs_asserts.sv ***
`timescale 1ns/10ps
module chb_coeff_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        dual_channel_mode,
    input wire logic [17:0] center_tap_coeff,
    input wire logic [11:0] sixth_tap_coeff,
    input wire logic [11:0] seventh_tap_coeff,
    input wire logic        chb_coeff_active,
    input wire logic        coeff_update
);
    wire in_map = reg_addr >= 12'h450 && reg_addr <= 12'h456;
    wire mwr    = reg_wr && in_map;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_msb_c; reg_rd && reg_addr == 12'h452 |=> !reg_rdata[1]; endproperty
    a_msb_c: assert property (p_msb_c) else $error("center top bit read back");
    property p_msb_o; reg_rd && (reg_addr == 12'h454 || reg_addr == 12'h456) |=> !reg_rdata[3];
    endproperty
    a_msb_o: assert property (p_msb_o) else $error("outer top bit read back");
    property p_ctr; reg_wr && reg_addr == 12'h450 && dual_channel_mode ##1 !reg_wr
        && dual_channel_mode |=> center_tap_coeff[7:0] == $past(reg_wdata, 2); endproperty
    a_ctr: assert property (p_ctr) else $error("center low byte wrong");
    property p_six; reg_wr && reg_addr == 12'h453 && dual_channel_mode ##1 !reg_wr
        && dual_channel_mode |=> sixth_tap_coeff[7:0] == $past(reg_wdata, 2); endproperty
    a_six: assert property (p_six) else $error("sixth low byte wrong");
    property p_sev; reg_wr && reg_addr == 12'h456 && dual_channel_mode ##1 !reg_wr
        && dual_channel_mode |=> {4'h0, seventh_tap_coeff[11:8]} == ($past(reg_wdata, 2) & 8'h0f);
    endproperty
    a_sev: assert property (p_sev) else $error("seventh high nibble wrong");
    property p_rt; reg_wr && reg_addr == 12'h453 ##1 reg_rd && reg_addr == 12'h453
        |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_rt: assert property (p_rt) else $error("sixth byte readback wrong");
    property p_single; !dual_channel_mode |=> center_tap_coeff == 18'h00000
        && sixth_tap_coeff == 12'h000 && seventh_tap_coeff == 12'h000; endproperty
    a_single: assert property (p_single) else $error("taps live in single mode");
    property p_act; rst_n |=> chb_coeff_active == $past(dual_channel_mode); endproperty
    a_act: assert property (p_act) else $error("active flag lag wrong");
    property p_upd; rst_n |=> coeff_update == $past(mwr); endproperty
    a_upd: assert property (p_upd) else $error("update pulse wrong");
    property p_unm; reg_rd && !in_map |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind chb_fir_coeff_regs chb_coeff_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dual_channel_mode(dual_channel_mode), .center_tap_coeff(center_tap_coeff),
    .sixth_tap_coeff(sixth_tap_coeff), .seventh_tap_coeff(seventh_tap_coeff),
    .chb_coeff_active(chb_coeff_active), .coeff_update(coeff_update));

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        dual = 1'b1;
    logic [7:0]  rdata;
    logic [17:0] ctr;
    logic [11:0] six;
    logic [11:0] sev;
    logic        act;
    logic        upd;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;
    // Rows: address, written byte, expected readback
    logic [27:0] rows [8] = '{28'h450a5a5, 28'h4515a5a, 28'h452fffd, 28'h4533c3c,
                              28'h454fff7, 28'h4558181, 28'h4560f07, 28'h457ff00};
    always #5 mclk = ~mclk;
    chb_fir_coeff_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .dual_channel_mode(dual), .center_tap_coeff(ctr), .sixth_tap_coeff(six),
        .seventh_tap_coeff(sev), .chb_coeff_active(act), .coeff_update(upd));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Read issued straight after the write, no idle cycle between
    task wr_rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        #1 chk(upd, a <= 12'h456);
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task close_out;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(12'h450 + 12'(i), 8'h00);
        foreach (rows[i]) wr_rd(rows[i][27:16], rows[i][15:8], rows[i][7:0]);
        @(posedge mclk);
        #1 chk(ctr, 18'h35aa5);
        chk(six, 12'hf3c);
        chk(sev, 12'hf81);
        @(posedge mclk) dual <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({act, ctr, six, sev}, 43'h0);
        @(posedge mclk) dual <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({act, ctr}, 19'h75aa5);
        @(posedge mclk) rst_n <= 1'b0;
        #1 chk({act, upd, ctr, six, sev, rdata}, 64'h0);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk({act, ctr, six, sev}, 64'h0000_0400_0000_0000);
        rd(12'h452, 8'h00);
        rd(12'h455, 8'h00);
        close_out();
    end
endmodule
